/* rtl/crc32_byte.sv */
`timescale 1ns/10ps
`include "tx_seq_cfg.svh"
module crc32_byte (
  input wire logic [31:0] crc_i,
  input wire logic [7:0] data_i,
  output logic [31:0] crc_o
);
  always_comb begin
    logic [31:0] c;
    c = crc_i;
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ data_i[i]) ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
    end
    crc_o = c;
  end
endmodule : crc32_byte

/* rtl/link_sync.sv */
`timescale 1ns/10ps
module link_sync (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // s2_q and s3_q feed the edge detector; s1_q stays private to the synchroniser
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign level_o = s2_q;
  assign rise_o = s2_q & ~s3_q;
endmodule : link_sync

/* rtl/mac_transmit_sequencer.sv */
`timescale 1ns/10ps
`include "tx_seq_cfg.svh"
module mac_transmit_sequencer #(
  parameter int DEFER_LIMIT = `DEFER_LIMIT_CYC
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire tx_seq_pkg::addr_t tx_start_pointer_i,
  input wire tx_seq_pkg::addr_t tx_end_pointer_i,
  input wire logic tx_request_set_i,
  input wire logic tx_request_clear_i,
  input wire logic dma_start_bit_i,
  input wire logic dma_busy_i,
  input wire logic cfg_crc_enable_i,
  input wire logic cfg_pad_enable_i,
  input wire logic cfg_huge_enable_i,
  input wire logic frame_length_check_enable_i,
  input wire logic [15:0] max_frame_length_i,
  input wire logic [3:0] retransmit_max_setting_i,
  input wire logic [5:0] collision_window_setting_i,
  input wire logic backpressure_applied_i,
  input wire logic link_clk_i,
  input wire logic carrier_i,
  input wire logic collision_i,
  input wire logic [7:0] mem_rdata_i,
  output logic [12:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  output logic tx_request_bit_o,
  output logic dma_grant_o,
  output logic tx_done_flag_o,
  output logic tx_abort_status_o,
  output logic late_collision_status_o,
  output logic [7:0] tx_data_o,
  output logic tx_en_o
);
  import tx_seq_pkg::*;

  mem_port_if mem ();
  logic link_rise;
  logic carrier_s;
  logic coll_s;
  logic [31:0] crc_next;
  logic coll_rise;
  logic coll_d1_q;

  link_sync u_clk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .async_i(link_clk_i),
                   .level_o(), .rise_o(link_rise));
  link_sync u_crs (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .async_i(carrier_i),
                   .level_o(carrier_s), .rise_o());
  link_sync u_col (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .async_i(collision_i),
                   .level_o(coll_s), .rise_o());

  tx_state_e st_q, st_d;
  logic req_q, req_d;
  addr_t ptr_q, ptr_d;
  logic [3:0] cnt_q, cnt_d;
  logic crc_en_q, crc_en_d;
  logic pad_en_q, pad_en_d;
  logic huge_en_q, huge_en_d;
  logic [31:0] crc_q, crc_d;
  logic [15:0] bytes_q, bytes_d;
  logic [15:0] wire_q, wire_d;
  logic [15:0] type_q, type_d;
  logic [15:0] op_q, op_d;
  logic [47:0] da_q, da_d;
  logic [3:0] coll_q, coll_d;
  logic [22:0] defer_q, defer_d;
  logic deferred_q, deferred_d;
  logic late_q, late_d;
  logic excoll_q, excoll_d;
  logic excdef_q, excdef_d;
  logic cancel_q, cancel_d;
  logic [55:0] tsv_q, tsv_d;
  logic done_q, done_d;
  logic abort_q, abort_d;
  logic dgrant_q, dgrant_d;
  logic [7:0] txd_q, txd_d;
  logic txen_q, txen_d;
  logic [12:0] maddr_q, maddr_d;
  logic mrd_q, mrd_d;
  logic mwr_q, mwr_d;
  logic [7:0] mwd_q, mwd_d;
  logic [7:0] cur_byte;
  logic late_stat_q, late_stat_d;
  logic [7:0] rbuf_q, rbuf_d;
  logic rd_d1_q;

  assign mem.rdata = mem_rdata_i;
  assign mem.addr = maddr_q;
  assign mem.rd = mrd_q;
  assign mem.wr = mwr_q;
  assign mem.wdata = mwd_q;

  // read data stands one cycle only; the byte waits for its link edge here
  assign cur_byte = (st_q == ST_PAD) ? 8'h00 : rbuf_q;
  crc32_byte u_crc (.crc_i(crc_q), .data_i(cur_byte), .crc_o(crc_next));

  // frame payload length excludes 14 header bytes; checked against length field
  function automatic logic len_mismatch(input logic [15:0] t, input logic [15:0] n);
    len_mismatch = (t <= `MAX_LEN_FIELD) && (t != n - 16'h000e) && (n > 16'h003c);
  endfunction : len_mismatch

  always_comb begin
    st_d = st_q;
    req_d = req_q;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    crc_en_d = crc_en_q;
    pad_en_d = pad_en_q;
    huge_en_d = huge_en_q;
    crc_d = crc_q;
    bytes_d = bytes_q;
    wire_d = wire_q;
    type_d = type_q;
    op_d = op_q;
    da_d = da_q;
    coll_d = coll_q;
    defer_d = defer_q;
    deferred_d = deferred_q;
    late_d = late_q;
    excoll_d = excoll_q;
    excdef_d = excdef_q;
    cancel_d = cancel_q;
    tsv_d = tsv_q;
    done_d = done_q;
    abort_d = abort_q;
    txd_d = txd_q;
    txen_d = txen_q;
    maddr_d = maddr_q;
    mrd_d = 1'b0;
    mwr_d = 1'b0;
    mwd_d = mwd_q;
    late_stat_d = late_stat_q;
    rbuf_d = rd_d1_q ? mem.rdata : rbuf_q;
    coll_rise = coll_s & ~coll_d1_q;
    if (tx_request_set_i && st_q == ST_IDLE) begin
      req_d = 1'b1;
      done_d = 1'b0;
    end
    if (tx_request_clear_i && req_q && st_q != ST_TSV && st_q != ST_DONE) begin
      cancel_d = 1'b1;
    end
    // dma only granted while no request is pending
    dgrant_d = dma_start_bit_i & ~req_d & (st_q == ST_IDLE);
    unique case (st_q)
      ST_IDLE: begin
        if (req_q) begin
          st_d = ST_WAIT_DMA;
          cancel_d = tx_request_clear_i;
          coll_d = 4'h0;
          wire_d = 16'h0000;
          defer_d = 23'h0;
          deferred_d = 1'b0;
          late_d = 1'b0;
          excoll_d = 1'b0;
          excdef_d = 1'b0;
        end
      end
      ST_WAIT_DMA: begin
        if (cancel_q) begin
          st_d = ST_TSV;
        end else if (!dma_busy_i) begin
          maddr_d = tx_start_pointer_i;
          mrd_d = 1'b1;
          st_d = ST_CTRL;
        end
      end
      ST_CTRL: begin
        if (!mrd_q) begin
          if (mem.rdata[`CTRL_OVR_BIT]) begin
            crc_en_d = mem.rdata[`CTRL_CRC_BIT];
            pad_en_d = mem.rdata[`CTRL_PAD_BIT];
            huge_en_d = mem.rdata[`CTRL_HUGE_BIT];
          end else begin
            crc_en_d = cfg_crc_enable_i;
            pad_en_d = cfg_pad_enable_i;
            huge_en_d = cfg_huge_enable_i;
          end
          st_d = ST_PRE;
          cnt_d = 4'h0;
        end
      end
      ST_PRE: begin
        if (cancel_q) begin
          st_d = ST_TSV;
          txen_d = 1'b0;
        end else if (carrier_s && !txen_q) begin
          // defer while medium busy
          defer_d = defer_q + 23'h1;
          deferred_d = 1'b1;
          if (defer_q >= DEFER_LIMIT[22:0]) begin
            excdef_d = 1'b1;
            st_d = ST_TSV;
          end
        end else if (link_rise) begin
          txen_d = 1'b1;
          txd_d = (cnt_q == `PREAMBLE_LEN) ? `SFD_BYTE : `PREAMBLE_BYTE;
          wire_d = wire_q + 16'h1;
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == `PREAMBLE_LEN) begin
            st_d = ST_DATA;
            ptr_d = tx_start_pointer_i + 13'h1;
            maddr_d = tx_start_pointer_i + 13'h1;
            mrd_d = 1'b1;
            bytes_d = 16'h0000;
            crc_d = `CRC_INIT;
          end
        end
      end
      ST_DATA, ST_PAD: begin
        if (cancel_q) begin
          st_d = ST_TSV;
          txen_d = 1'b0;
        end else if (coll_rise) begin
          txen_d = 1'b0;
          if (bytes_q > {10'h0, collision_window_setting_i}) begin
            late_d = 1'b1;
            st_d = ST_TSV;
          end else if (coll_q >= retransmit_max_setting_i) begin
            excoll_d = 1'b1;
            st_d = ST_TSV;
          end else begin
            coll_d = coll_q + 4'h1;
            st_d = ST_PRE;
            cnt_d = 4'h0;
          end
        end else if (link_rise) begin
          txd_d = cur_byte;
          crc_d = crc_next;
          bytes_d = bytes_q + 16'h1;
          wire_d = wire_q + 16'h1;
          if (bytes_q < 16'h0006) da_d = {da_q[39:0], cur_byte};
          if (bytes_q == 16'h000c) type_d[15:8] = cur_byte;
          if (bytes_q == 16'h000d) type_d[7:0] = cur_byte;
          if (bytes_q == 16'h000e) op_d[15:8] = cur_byte;
          if (bytes_q == 16'h000f) op_d[7:0] = cur_byte;
          ptr_d = ptr_q + 13'h1;
          maddr_d = ptr_q + 13'h1;
          mrd_d = 1'b1;
          if (st_q == ST_PAD || ptr_q == tx_end_pointer_i) begin
            if (pad_en_q && crc_en_q && bytes_q + 16'h1 < `MIN_FRAME_NOCRC) begin
              st_d = ST_PAD;
            end else if (crc_en_q) begin
              st_d = ST_CRC;
              cnt_d = 4'h0;
            end else begin
              st_d = ST_TSV;
            end
          end
        end
      end
      ST_CRC: begin
        if (link_rise) begin
          txd_d = ~crc_q[7:0];
          crc_d = {8'hff, crc_q[31:8]};
          bytes_d = bytes_q + 16'h1;
          wire_d = wire_q + 16'h1;
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == 4'h3) st_d = ST_TSV;
        end
      end
      ST_TSV: begin
        if (cnt_q != 4'hf) begin
          tsv_d = {4'h0, type_q == `VLAN_TYPE, backpressure_applied_i,
                   type_q == `PAUSE_TYPE && op_q == 16'h0001, type_q == `PAUSE_TYPE,
                   wire_q, 1'b0,
                   !huge_en_q && bytes_q > max_frame_length_i,
                   late_q, excoll_q, excdef_q, deferred_q && !excdef_q,
                   da_q == 48'hffffffffffff, da_q[40] && da_q != 48'hffffffffffff,
                   !(cancel_q || late_q || excoll_q || excdef_q),
                   type_q > `MAX_LEN_FIELD,
                   frame_length_check_enable_i && len_mismatch(type_q, bytes_q),
                   1'b0, coll_q, bytes_q};
          cnt_d = 4'hf;
          ptr_d = tx_end_pointer_i + 13'h1;
        end else begin
          maddr_d = ptr_q;
          mwr_d = 1'b1;
          mwd_d = tsv_q[7:0];
          tsv_d = {8'h00, tsv_q[55:8]};
          ptr_d = ptr_q + 13'h1;
          if (ptr_q == tx_end_pointer_i + 13'(`TSV_BYTES)) st_d = ST_DONE;
        end
      end
      ST_DONE: begin
        req_d = 1'b0;
        late_stat_d = late_q;
        done_d = 1'b1;
        abort_d = cancel_q | late_q | excoll_q | excdef_q;
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    // last byte keeps tx_en for its whole link period
    if (link_rise && (st_q == ST_TSV || st_q == ST_DONE || st_q == ST_IDLE)) begin
      txen_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= ST_IDLE;
      req_q <= 1'b0;
      ptr_q <= '0;
      cnt_q <= 4'h0;
      crc_en_q <= 1'b0;
      pad_en_q <= 1'b0;
      huge_en_q <= 1'b0;
      crc_q <= `CRC_INIT;
      bytes_q <= 16'h0000;
      wire_q <= 16'h0000;
      type_q <= 16'h0000;
      op_q <= 16'h0000;
      da_q <= 48'h0;
      coll_q <= 4'h0;
      defer_q <= 23'h0;
      deferred_q <= 1'b0;
      late_q <= 1'b0;
      excoll_q <= 1'b0;
      excdef_q <= 1'b0;
      cancel_q <= 1'b0;
      tsv_q <= 56'h0;
      done_q <= 1'b0;
      abort_q <= 1'b0;
      dgrant_q <= 1'b0;
      txd_q <= 8'h00;
      txen_q <= 1'b0;
      maddr_q <= 13'h0;
      mrd_q <= 1'b0;
      mwr_q <= 1'b0;
      mwd_q <= 8'h00;
      coll_d1_q <= 1'b0;
      late_stat_q <= 1'b0;
      rbuf_q <= 8'h00;
      rd_d1_q <= 1'b0;
    end else begin
      st_q <= st_d;
      req_q <= req_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      crc_en_q <= crc_en_d;
      pad_en_q <= pad_en_d;
      huge_en_q <= huge_en_d;
      crc_q <= crc_d;
      bytes_q <= bytes_d;
      wire_q <= wire_d;
      type_q <= type_d;
      op_q <= op_d;
      da_q <= da_d;
      coll_q <= coll_d;
      defer_q <= defer_d;
      deferred_q <= deferred_d;
      late_q <= late_d;
      excoll_q <= excoll_d;
      excdef_q <= excdef_d;
      cancel_q <= cancel_d;
      tsv_q <= tsv_d;
      done_q <= done_d;
      abort_q <= abort_d;
      dgrant_q <= dgrant_d;
      txd_q <= txd_d;
      txen_q <= txen_d;
      maddr_q <= maddr_d;
      mrd_q <= mrd_d;
      mwr_q <= mwr_d;
      mwd_q <= mwd_d;
      coll_d1_q <= coll_s;
      late_stat_q <= late_stat_d;
      rbuf_q <= rbuf_d;
      rd_d1_q <= mrd_q;
    end
  end

  assign mem_addr_o = maddr_q;
  assign mem_rd_o = mrd_q;
  assign mem_wr_o = mwr_q;
  assign mem_wdata_o = mwd_q;
  assign tx_request_bit_o = req_q;
  assign dma_grant_o = dgrant_q;
  assign tx_done_flag_o = done_q;
  assign tx_abort_status_o = abort_q;
  assign late_collision_status_o = late_stat_q;
  assign tx_data_o = txd_q;
  assign tx_en_o = txen_q;
endmodule : mac_transmit_sequencer

/* rtl/mem_port_if.sv */
`timescale 1ns/10ps
interface mem_port_if;
  logic [12:0] addr;
  logic rd;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport master (output addr, output rd, output wr, output wdata, input rdata);
  modport slave (input addr, input rd, input wr, input wdata, output rdata);
endinterface : mem_port_if

/* rtl/tx_seq_cfg.svh */
`ifndef TX_SEQ_CFG_SVH
`define TX_SEQ_CFG_SVH
`define ADDR_W 13
`define CTRL_OVR_BIT 0
`define CTRL_CRC_BIT 1
`define CTRL_PAD_BIT 2
`define CTRL_HUGE_BIT 3
`define PREAMBLE_BYTE 8'h55
`define SFD_BYTE 8'hd5
`define PREAMBLE_LEN 4'h7
`define MIN_FRAME_NOCRC 16'h003c
`define TSV_BYTES 3'h7
`define VLAN_TYPE 16'h8100
`define PAUSE_TYPE 16'h8808
`define MAX_LEN_FIELD 16'h05dc
`define DEFER_BIT_TIMES 24287
`define BIT_NS 100
`define DEFER_LIMIT_CYC ((`DEFER_BIT_TIMES * `BIT_NS) / 20)
`define CRC_INIT 32'hffffffff
`define CRC_POLY 32'hedb88320
`endif

/* rtl/tx_seq_pkg.sv */
package tx_seq_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_WAIT_DMA = 4'h1,
    ST_CTRL = 4'h2,
    ST_PRE = 4'h3,
    ST_DATA = 4'h4,
    ST_PAD = 4'h5,
    ST_CRC = 4'h6,
    ST_TSV = 4'h7,
    ST_DONE = 4'h8
  } tx_state_e;
  typedef logic [12:0] addr_t;
endpackage : tx_seq_pkg

/* sim/buffer_mem_model.sv */
`timescale 1ns/10ps
module buffer_mem_model (
  input wire logic clk_sys_i,
  input wire logic [12:0] mem_addr_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic [7:0] mem_wdata_i,
  output logic [7:0] mem_rdata_o
);
  logic [7:0] mem [0:8191];
  initial mem_rdata_o = 8'h00;
  // idle cycles toggle the data so a late sample cannot match by luck
  always @(posedge clk_sys_i) begin
    if (mem_rd_i) mem_rdata_o <= mem[mem_addr_i];
    else mem_rdata_o <= ~mem_rdata_o;
    if (mem_wr_i) mem[mem_addr_i] <= mem_wdata_i;
  end
endmodule : buffer_mem_model

/* sim/mac_transmit_sequencer_checker.sv */
`timescale 1ns/10ps
`include "tx_seq_cfg.svh"
module mac_transmit_sequencer_checker (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire tx_seq_pkg::addr_t tx_start_pointer_i,
  input wire tx_seq_pkg::addr_t tx_end_pointer_i,
  input wire logic tx_request_set_i,
  input wire logic dma_busy_i,
  input wire logic [12:0] mem_addr_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic tx_request_bit_o,
  input wire logic dma_grant_o,
  input wire logic tx_done_flag_o,
  input wire logic tx_abort_status_o,
  input wire logic late_collision_status_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_en_o
);
  import tx_seq_pkg::*;
  logic [12:0] wr_off;
  logic [3:0] wr_cnt_d;
  logic [3:0] wr_cnt_q;
  assign wr_off = mem_addr_o - tx_end_pointer_i;
  always_comb begin
    wr_cnt_d = wr_cnt_q;
    if (tx_request_set_i && !tx_request_bit_o) wr_cnt_d = 4'h0;
    else if (mem_wr_o) wr_cnt_d = wr_cnt_q + 4'h1;
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) wr_cnt_q <= 4'h0;
    else wr_cnt_q <= wr_cnt_d;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  a_grant_held_off: assert property (tx_request_bit_o |-> !dma_grant_o)
    else $error("dma granted while request pending");
  a_request_taken: assert property (!tx_request_bit_o && tx_request_set_i |=> tx_request_bit_o)
    else $error("request not taken");
  a_ctrl_read_first: assert property ($rose(tx_request_bit_o) && !dma_busy_i |->
    ##[1:3] (mem_rd_o && mem_addr_o == tx_start_pointer_i))
    else $error("control byte not read first");
  a_dma_defers: assert property (dma_busy_i && tx_request_bit_o && !tx_en_o |-> !mem_rd_o)
    else $error("read while dma active");
  a_status_place: assert property (mem_wr_o |-> wr_off >= 13'h1 && wr_off <= 13'h7)
    else $error("status write outside end+1..end+7");
  a_seven_writes: assert property ($fell(tx_request_bit_o) |-> wr_cnt_d == 4'h7)
    else $error("status vector not seven bytes");
  a_done_at_end: assert property ($fell(tx_request_bit_o) |-> tx_done_flag_o)
    else $error("done flag missing at end");
  a_done_cleared: assert property ($rose(tx_request_bit_o) |-> !tx_done_flag_o)
    else $error("done flag kept over new request");
  a_late_aborts: assert property (late_collision_status_o |-> tx_abort_status_o)
    else $error("late collision without abort");
  a_preamble_first: assert property ($rose(tx_en_o) |-> tx_data_o == `PREAMBLE_BYTE)
    else $error("frame not opened by preamble");
  c_packet_end: cover property ($fell(tx_request_bit_o));
  c_status_write: cover property (mem_wr_o);
  c_dma_wait: cover property (dma_busy_i && tx_request_bit_o);
endmodule : mac_transmit_sequencer_checker

bind mac_transmit_sequencer mac_transmit_sequencer_checker u_mac_transmit_sequencer_checker (
  .clk_sys_i, .resetn_i, .tx_start_pointer_i, .tx_end_pointer_i, .tx_request_set_i,
  .dma_busy_i, .mem_addr_o, .mem_rd_o, .mem_wr_o, .tx_request_bit_o, .dma_grant_o,
  .tx_done_flag_o, .tx_abort_status_o, .late_collision_status_o, .tx_data_o, .tx_en_o);

/* sim/test_mac_transmit_sequencer.sv */
`timescale 1ns/10ps
module test_mac_transmit_sequencer;
  import tx_seq_pkg::*;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic link_clk = 1'b0;
  addr_t start_ptr = 13'h0120;
  addr_t end_ptr = 13'h0000;
  logic req_set = 1'b0, req_clr = 1'b0, dma_start = 1'b0, dma_busy = 1'b0;
  logic crc_en = 1'b1, pad_en = 1'b1, huge_en = 1'b0, bp = 1'b0;
  logic len_chk = 1'b0;
  logic [3:0] retry_max = 4'hf;
  logic [12:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, tx_data;
  logic mem_rd, mem_wr, req_bit, grant, done, abort, late, tx_en;
  logic [15:0] wire_q[$], tsv_q[$];
  logic [15:0] wn, sn;
  logic [31:0] crc;
  logic skip_wire = 1'b0;
  int error_cnt = 0, samples_checked = 0, seed = 89, tno = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  // link clock only runs while a packet is under way
  always #80 link_clk = (req_bit === 1'b1 || tx_en === 1'b1) ? ~link_clk : 1'b0;
  mac_transmit_sequencer #(.DEFER_LIMIT(50)) u_mac_transmit_sequencer (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .tx_start_pointer_i(start_ptr),
    .tx_end_pointer_i(end_ptr), .tx_request_set_i(req_set), .tx_request_clear_i(req_clr),
    .dma_start_bit_i(dma_start), .dma_busy_i(dma_busy), .cfg_crc_enable_i(crc_en),
    .cfg_pad_enable_i(pad_en), .cfg_huge_enable_i(huge_en),
    .frame_length_check_enable_i(len_chk), .max_frame_length_i(16'h05ee),
    .retransmit_max_setting_i(retry_max), .collision_window_setting_i(6'h3f),
    .backpressure_applied_i(bp), .link_clk_i(link_clk), .carrier_i(1'b0),
    .collision_i(1'b0), .mem_rdata_i(mem_rdata), .mem_addr_o(mem_addr), .mem_rd_o(mem_rd),
    .mem_wr_o(mem_wr), .mem_wdata_o(mem_wdata), .tx_request_bit_o(req_bit),
    .dma_grant_o(grant), .tx_done_flag_o(done), .tx_abort_status_o(abort),
    .late_collision_status_o(late), .tx_data_o(tx_data), .tx_en_o(tx_en));
  buffer_mem_model u_buffer_mem_model (.clk_sys_i(clk_sys_i), .mem_addr_i(mem_addr),
    .mem_rd_i(mem_rd), .mem_wr_i(mem_wr), .mem_wdata_i(mem_wdata), .mem_rdata_o(mem_rdata));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic note(input logic [7:0] m, input logic [7:0] v);
    tsv_q.push_back({m, v & m});
  endtask : note
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 32'hedb88320 : 32'h0);
    return c;
  endfunction : crc_step
  always @(posedge link_clk) begin
    if (tx_en === 1'b1 && !skip_wire) begin
      if (wire_q.size() > 0) begin
        wn = wire_q.pop_front();
        chk("wire_byte", wn[7:0], tx_data);
      end else chk("wire_extra", 8'h00, 8'h01);
    end
  end
  always @(posedge clk_sys_i) begin
    if (mem_wr === 1'b1 && tsv_q.size() > 0) begin
      sn = tsv_q.pop_front();
      chk("status_byte", sn[7:0], mem_wdata & sn[15:8]);
    end
  end
  task automatic send(input logic [7:0] ctrl, input int n, input logic bc, input logic vlan,
                      input int cancel_at, input int dma_hold);
    logic [7:0] b;
    logic [7:0] m;
    logic use_crc, use_pad;
    int len;
    use_crc = ctrl[0] ? ctrl[1] : crc_en;
    use_pad = (ctrl[0] ? ctrl[2] : pad_en) && use_crc;
    u_buffer_mem_model.mem[start_ptr] = ctrl;
    crc = 32'hffffffff;
    skip_wire = (cancel_at > 0);
    for (int i = 0; i < 8; i++) wire_q.push_back({8'hff, (i == 7) ? 8'hd5 : 8'h55});
    len = (use_pad && n < 60) ? 60 : n;
    for (int i = 0; i < len; i++) begin
      if (i >= n) b = 8'h00;
      else if (i < 6) b = bc ? 8'hff : ((i == 0) ? 8'h02 : 8'($random(seed)));
      else if (i == 12) b = vlan ? 8'h81 : 8'h08;
      else if (i == 13) b = 8'h00;
      else b = 8'($random(seed));
      if (i < n) u_buffer_mem_model.mem[start_ptr + 13'(i + 1)] = b;
      crc = crc_step(crc, b);
      wire_q.push_back({8'hff, b});
    end
    if (use_crc) for (int i = 0; i < 4; i++) wire_q.push_back({8'hff, ~crc[8*i +: 8]});
    len = len + (use_crc ? 4 : 0);
    end_ptr = start_ptr + 13'(n);
    m = (cancel_at == 0) ? 8'hff : 8'h00;
    note(m, 8'(len));
    note(m, 8'(len >> 8));
    note(8'h80 | (m & (use_crc ? 8'h7f : 8'h6f)), {cancel_at == 0, 7'h40});
    note(8'h80 | (m & (bc ? 8'hfe : 8'hff)), {6'h00, bc, 1'b0});
    // no collisions here: wire total is preamble plus frame
    note(m, 8'(len + 8));
    note(m, 8'((len + 8) >> 8));
    note(8'hf0 | (m & 8'h0f), {4'h0, vlan, bp, 2'b00});
    dma_busy = (dma_hold > 0);
    @(negedge clk_sys_i) req_set = 1'b1;
    @(negedge clk_sys_i) req_set = 1'b0;
    repeat (dma_hold) @(negedge clk_sys_i);
    dma_busy = 1'b0;
    repeat (20) @(negedge clk_sys_i);
    req_set = 1'b1;
    @(negedge clk_sys_i) req_set = 1'b0;
    if (cancel_at > 0) begin
      repeat (cancel_at) @(negedge clk_sys_i);
      req_clr = 1'b1;
      @(negedge clk_sys_i) req_clr = 1'b0;
    end
    for (int w = 0; w < 4000 && done !== 1'b1; w++) @(negedge clk_sys_i);
    repeat (2) @(negedge clk_sys_i);
    chk("done_flag", 8'h01, {7'h00, done});
    chk("request_bit", 8'h00, {7'h00, req_bit});
    chk("dma_grant", {7'h00, dma_start}, {7'h00, grant});
    chk("abort_status", {7'h00, cancel_at > 0}, {7'h00, abort});
    chk("late_status", 8'h00, {7'h00, late});
    if (cancel_at == 0) chk("wire_left", 8'h00, 8'(wire_q.size()));
    chk("status_left", 8'h00, 8'(tsv_q.size()));
    wire_q.delete();
    skip_wire = 1'b0;
    tno++;
    $display("packet test %0d done", tno);
  endtask : send
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
  initial begin
    retry_max = 4'($random(seed));
    repeat (8) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    @(negedge clk_sys_i);
    send(8'h00, 20, 1'b0, 1'b0, 0, 0);
    bp = 1'b1;
    len_chk = 1'b1;
    send(8'h09, 70, 1'b1, 1'b1, 0, 0);
    bp = 1'b0;
    len_chk = 1'b0;
    dma_start = 1'b1;
    send(8'h07, 59, 1'b0, 1'b0, 0, 30);
    dma_start = 1'b0;
    send(8'h00, 40, 1'b0, 1'b0, 300, 0);
    complete_run();
  end
endmodule : test_mac_transmit_sequencer
